/* design/dcc_defs.vh */
// dcc_defs.vh: register map, command characters and field limits
// Assumes inclusion by every file of the command controller except the averager.
`ifndef DCC_DEFS_VH
`define DCC_DEFS_VH
// APB byte offsets
`define DCC_A_CMD 8'h00
`define DCC_A_STAT 8'h04
`define DCC_A_CFG 8'h08
`define DCC_A_IO 8'h0C
`define DCC_A_RES 8'h10
// Command word fields
`define DCC_F_CHR 7:0
`define DCC_F_ARG 23:8
`define DCC_F_NIB 3:0
`define DCC_F_CHAN 2:0
`define DCC_F_RATE 10:0
`define DCC_F_HI16 23:8
// Status bits
`define DCC_S_BUSY 0
`define DCC_S_STBY 1
`define DCC_S_REF 2
`define DCC_S_SKIP 3
`define DCC_S_RANGE 4
`define DCC_S_RES 5
`define DCC_S_UWAIT 6
`define DCC_S_AWAIT 7
// Command characters
`define DCC_C_AVG 8'h41
`define DCC_C_STBY 8'h42
`define DCC_C_CHAN 8'h43
`define DCC_C_DIN 8'h44
`define DCC_C_EXT 8'h45
`define DCC_C_FS 8'h46
`define DCC_C_GAIN 8'h47
`define DCC_C_OFS 8'h4F
`define DCC_C_POL 8'h50
`define DCC_C_RATE 8'h52
`define DCC_C_SYS 8'h53
`define DCC_C_FILT 8'h54
`define DCC_C_DOUT 8'h55
`define DCC_C_CONV 8'h56
`define DCC_C_WORD 8'h57
`define DCC_C_PLUS 8'h2B
`define DCC_C_MINUS 8'h2D
`define DCC_C_ENTER 8'h0D
// Settings and limits
`define DCC_G1 3'h0
`define DCC_CH_FS 3'h6
`define DCC_CH_ZERO 3'h7
`define DCC_CH_RST 3'h0
`define DCC_RATE_MIN 16'h000A
`define DCC_RATE_MAX 16'h0403
`define DCC_RATE_RST 11'h00A
`define DCC_EXP_MAX 4'hF
`define DCC_FLT_400 2'h0
`define DCC_FLT_4 2'h2
`define DCC_ZERO_BI 25'h0800000
`define DCC_FS_MAX 24'hFFFFFF
`define DCC_OFS_LIM 25'h00CCCCC
`define DCC_OFS_NEG 25'h1F33334
`endif

/* design/dcc_ofs.v */
// dcc_ofs.v: offset correction of raw converter codes, registered
// Assumes a 25-bit signed offset held steady between calibrations.
`timescale 1ns/1ps
`include "dcc_defs.vh"
module dcc_ofs (
  // Clock and reset
  input wire clk_i,
  input wire rstn_i,
  // Raw sample in
  input wire valid_i,
  input wire [23:0] raw_i,
  input wire [24:0] ofs_i,
  // Corrected sample out
  output reg valid_o,
  output reg [23:0] data_o
);
  ////////////////////////////////////////////////////////////////
  // One extra bit of headroom so both saturation ends are visible
  wire [25:0] diff = {2'h0, raw_i} - {ofs_i[24], ofs_i};

  // Saturate into the unsigned 24-bit count range
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      valid_o <= 1'h0;
      data_o <= 24'h000000;
    end else begin
      valid_o <= valid_i;
      if (valid_i) begin
        if (diff[25])
          data_o <= 24'h000000;
        else if (diff[24])
          data_o <= `DCC_FS_MAX;
        else
          data_o <= diff[23:0];
      end
    end
  end
endmodule // dcc_ofs

/* design/dcc_avg.v */
// dcc_avg.v: power-of-two block averager, one result per group
// Assumes exp_i is stable for the whole group; clr_i starts a new one.
`timescale 1ns/1ps
module dcc_avg #(
  parameter W = 24,
  parameter EW = 4
) (
  // Clock and reset
  input wire clk_i,
  input wire rstn_i,
  // Samples in
  input wire clr_i,
  input wire valid_i,
  input wire [W-1:0] data_i,
  input wire [EW-1:0] exp_i,
  // Results out
  output reg ack_o,
  output reg done_o,
  output reg [W-1:0] avg_o
);
  ////////////////////////////////////////////////////////////////
  localparam CW = (1 << EW);
  localparam AW = W + CW - 1;
  reg [AW-1:0] acc;
  reg [CW-1:0] cnt;
  wire [CW-1:0] one = {{(CW-1){1'h0}}, 1'h1};
  wire [AW-1:0] sum = acc + {{(CW-1){1'h0}}, data_i};
  wire [CW-1:0] lim = (one << exp_i) - one;
  wire [AW-1:0] shf = sum >> exp_i;

  // Accumulate; the wide sum never overflows at the largest group
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      acc <= {AW{1'h0}};
      cnt <= {CW{1'h0}};
      ack_o <= 1'h0;
      done_o <= 1'h0;
      avg_o <= {W{1'h0}};
    end else begin
      ack_o <= 1'h0;
      done_o <= 1'h0;
      if (clr_i) begin
        acc <= {AW{1'h0}};
        cnt <= {CW{1'h0}};
      end else if (valid_i) begin
        ack_o <= 1'h1;
        if (cnt == lim) begin
          avg_o <= shf[W-1:0];
          done_o <= 1'h1;
          acc <= {AW{1'h0}};
          cnt <= {CW{1'h0}};
        end else begin
          acc <= sum;
          cnt <= cnt + one;
        end
      end
    end
  end
endmodule // dcc_avg

/* design/dcc_ctrl.v */
// dcc_ctrl.v: command interpreter of a 24-bit acquisition unit
// Assumes an APB master on CLK_I and a converter that answers every
// start or full-scale request with one ADC_DONE_I pulse.
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ps
`include "dcc_defs.vh"
module dcc_ctrl #(
  parameter [15:0] SETTLE_CYC = 16'h03E8
) (
  // Clock and reset
  input wire CLK_I,
  input wire RESETN_I,
  // APB slave
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [7:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  output reg [31:0] PRDATA_O,
  output wire PREADY_O,
  output wire PSLVERR_O,
  // Digital lines
  input wire [7:0] DIN_I,
  output reg [7:0] DOUT_O,
  output wire [3:0] ISO_O,
  output wire [3:0] ISO_OE_O,
  // Converter control
  output reg [2:0] ADC_GAIN_O,
  output reg ADC_WORD16_O,
  output reg [10:0] ADC_RATE_O,
  output reg ADC_BIPOLAR_O,
  output reg [1:0] ADC_FILTER_O,
  output reg [2:0] ADC_CHAN_O,
  output reg ADC_STANDBY_O,
  output reg ADC_START_O,
  output reg ADC_FSCAL_O,
  // Converter answer
  input wire ADC_DONE_I,
  input wire [23:0] ADC_DATA_I
);
  ////////////////////////////////////////////////////////////////
  localparam ST_IDLE = 5'h01;
  localparam ST_SETTLE = 5'h02;
  localparam ST_CONV = 5'h04;
  localparam ST_AVG = 5'h08;
  localparam ST_FSCAL = 5'h10;

  reg [4:0] state;
  reg [2:0] gain;
  reg word16;
  reg bipolar;
  reg [1:0] filter;
  reg [2:0] chan;
  reg [2:0] chan_save;
  reg [3:0] avg_exp;
  reg [3:0] avg_pend;
  reg [10:0] rate;
  reg stby;
  reg [3:0] isolated_code_value;
  reg [7:0] din_last;
  reg u_wait;
  reg a_wait;
  reg sys;
  reg ofs_mode;
  reg avg_clr;
  reg [15:0] settle_cnt;
  reg refused;
  reg skipped;
  reg range_err;
  reg res_rdy;
  reg [23:0] result;
  reg [24:0] offset;
  wire cor_v;
  wire [23:0] cor_d;
  wire avg_ack;
  wire avg_done;
  wire [23:0] avg_d;

  ////////////////////////////////////////////////////////////////
  // APB decode; zero wait states, so every access ends in one cycle
  wire acc_ph = PSEL_I & PENABLE_I;
  wire wr = acc_ph & PWRITE_I;
  wire mapped = (PADDR_I == `DCC_A_CMD) | (PADDR_I == `DCC_A_STAT) |
    (PADDR_I == `DCC_A_CFG) | (PADDR_I == `DCC_A_IO) |
    (PADDR_I == `DCC_A_RES);
  wire cmd_wr = wr & (PADDR_I == `DCC_A_CMD);
  wire stat_wr = wr & (PADDR_I == `DCC_A_STAT);
  wire res_rd = acc_ph & ~PWRITE_I & (PADDR_I == `DCC_A_RES);
  wire [7:0] chr = PWDATA_I[`DCC_F_CHR];
  wire [15:0] arg = PWDATA_I[`DCC_F_ARG];
  wire busy = (state != ST_IDLE);
  wire conv_act = (state == ST_CONV) | (state == ST_AVG) |
    (state == ST_FSCAL);
  assign PREADY_O = 1'h1;
  assign PSLVERR_O = acc_ph & ~mapped;

  // Open-drain style: only the enable moves, the level is always low
  assign ISO_O = 4'h0;
  assign ISO_OE_O = isolated_code_value;

  ////////////////////////////////////////////////////////////////
  // Gain argument must be one of the eight powers of two
  function [3:0] g_dec;
    input [15:0] a;
    begin
      case (a)
        16'h0001: g_dec = {1'h1, 3'h0};
        16'h0002: g_dec = {1'h1, 3'h1};
        16'h0004: g_dec = {1'h1, 3'h2};
        16'h0008: g_dec = {1'h1, 3'h3};
        16'h0010: g_dec = {1'h1, 3'h4};
        16'h0020: g_dec = {1'h1, 3'h5};
        16'h0040: g_dec = {1'h1, 3'h6};
        16'h0080: g_dec = {1'h1, 3'h7};
        default: g_dec = 4'h0;
      endcase
    end
  endfunction
  wire [3:0] g_res = g_dec(arg);

  // Offset relative to the zero code of the present polarity
  wire [24:0] zero_code = bipolar ? `DCC_ZERO_BI : 25'h0000000;
  wire signed [24:0] ofs_raw = {1'h0, ADC_DATA_I} - zero_code;
  wire ofs_hi = ofs_raw > $signed(`DCC_OFS_LIM);
  wire ofs_lo = ofs_raw < $signed(`DCC_OFS_NEG);
  wire [24:0] ofs_clip = ofs_hi ? `DCC_OFS_LIM :
    (ofs_lo ? `DCC_OFS_NEG : ofs_raw);
  wire raw_v = ADC_DONE_I & (state == ST_CONV) & ~ofs_mode;

  ////////////////////////////////////////////////////////////////
  // Sample path: correction then block averaging
  dcc_ofs u_ofs (
    .clk_i(CLK_I),
    .rstn_i(RESETN_I),
    .valid_i(raw_v),
    .raw_i(ADC_DATA_I),
    .ofs_i(offset),
    .valid_o(cor_v),
    .data_o(cor_d)
  );

  dcc_avg #(.W(24), .EW(4)) u_avg (
    .clk_i(CLK_I),
    .rstn_i(RESETN_I),
    .clr_i(avg_clr),
    .valid_i(cor_v),
    .data_i(cor_d),
    .exp_i(avg_exp),
    .ack_o(avg_ack),
    .done_o(avg_done),
    .avg_o(avg_d)
  );

  ////////////////////////////////////////////////////////////////
  // Command interpreter and sequencer
  always @(posedge CLK_I) begin
    if (!RESETN_I) begin
      state <= ST_IDLE;
      gain <= `DCC_G1;
      word16 <= 1'h0;
      bipolar <= 1'h1;
      filter <= `DCC_FLT_400;
      chan <= `DCC_CH_RST;
      chan_save <= `DCC_CH_RST;
      avg_exp <= 4'h0;
      avg_pend <= 4'h0;
      rate <= `DCC_RATE_RST;
      stby <= 1'h0;
      isolated_code_value <= 4'h0;
      din_last <= 8'h00;
      DOUT_O <= 8'h00;
      u_wait <= 1'h0;
      a_wait <= 1'h0;
      sys <= 1'h0;
      ofs_mode <= 1'h0;
      avg_clr <= 1'h0;
      settle_cnt <= 16'h0000;
      refused <= 1'h0;
      skipped <= 1'h0;
      range_err <= 1'h0;
      res_rdy <= 1'h0;
      result <= 24'h000000;
      offset <= 25'h0000000;
      ADC_START_O <= 1'h0;
      ADC_FSCAL_O <= 1'h0;
    end else begin
      ADC_START_O <= 1'h0;
      ADC_FSCAL_O <= 1'h0;
      avg_clr <= 1'h0;
      // Write-one-to-clear first so a same-cycle set below wins
      if (stat_wr) begin
        refused <= refused & ~PWDATA_I[`DCC_S_REF];
        skipped <= skipped & ~PWDATA_I[`DCC_S_SKIP];
        range_err <= range_err & ~PWDATA_I[`DCC_S_RANGE];
      end
      if (res_rd)
        res_rdy <= 1'h0;
      if (cmd_wr && busy)
        refused <= 1'h1;
      case (state)
        ST_IDLE: begin
          if (cmd_wr) begin
            if (u_wait) begin
              DOUT_O <= chr;
              u_wait <= 1'h0;
            end else if (a_wait) begin
              case (chr)
                `DCC_C_PLUS: begin
                  if (avg_pend != `DCC_EXP_MAX)
                    avg_pend <= avg_pend + 4'h1;
                end
                `DCC_C_MINUS: begin
                  if (avg_pend != 4'h0)
                    avg_pend <= avg_pend - 4'h1;
                end
                `DCC_C_ENTER: begin
                  avg_exp <= avg_pend;
                  a_wait <= 1'h0;
                end
                default: begin
                  a_wait <= 1'h0;
                  refused <= 1'h1;
                end
              endcase
            end else begin
              case (chr)
                `DCC_C_DIN: din_last <= DIN_I;
                `DCC_C_EXT: isolated_code_value <= arg[`DCC_F_NIB];
                `DCC_C_DOUT: u_wait <= 1'h1;
                `DCC_C_GAIN: begin
                  if (g_res[3])
                    gain <= g_res[2:0];
                  else
                    refused <= 1'h1;
                end
                `DCC_C_WORD: word16 <= ~word16;
                `DCC_C_RATE: begin
                  if (arg >= `DCC_RATE_MIN && arg <= `DCC_RATE_MAX)
                    rate <= arg[`DCC_F_RATE];
                  else
                    refused <= 1'h1;
                end
                `DCC_C_POL: bipolar <= ~bipolar;
                `DCC_C_AVG: begin
                  a_wait <= 1'h1;
                  avg_pend <= avg_exp;
                end
                `DCC_C_FILT: begin
                  if (filter == `DCC_FLT_4)
                    filter <= `DCC_FLT_400;
                  else
                    filter <= filter + 2'h1;
                end
                `DCC_C_STBY: stby <= ~stby;
                `DCC_C_CHAN: chan <= arg[`DCC_F_CHAN];
                `DCC_C_CONV: begin
                  if (stby) begin
                    refused <= 1'h1;
                  end else begin
                    avg_clr <= 1'h1;
                    ofs_mode <= 1'h0;
                    sys <= 1'h0;
                    ADC_START_O <= 1'h1;
                    state <= ST_CONV;
                  end
                end
                `DCC_C_OFS: begin
                  if (stby) begin
                    refused <= 1'h1;
                  end else begin
                    ofs_mode <= 1'h1;
                    sys <= 1'h0;
                    ADC_START_O <= 1'h1;
                    state <= ST_CONV;
                  end
                end
                `DCC_C_FS: begin
                  if (stby) begin
                    refused <= 1'h1;
                  end else begin
                    sys <= 1'h0;
                    ADC_FSCAL_O <= 1'h1;
                    state <= ST_FSCAL;
                  end
                end
                `DCC_C_SYS: begin
                  if (stby) begin
                    refused <= 1'h1;
                  end else if (gain != `DCC_G1) begin
                    skipped <= 1'h1;
                  end else begin
                    sys <= 1'h1;
                    ofs_mode <= 1'h1;
                    chan_save <= chan;
                    chan <= `DCC_CH_ZERO;
                    settle_cnt <= SETTLE_CYC;
                    state <= ST_SETTLE;
                  end
                end
                default: refused <= 1'h1;
              endcase
            end
          end
        end
        // Channel settling before a calibration step
        ST_SETTLE: begin
          if (settle_cnt == 16'h0000) begin
            if (ofs_mode) begin
              ADC_START_O <= 1'h1;
              state <= ST_CONV;
            end else begin
              ADC_FSCAL_O <= 1'h1;
              state <= ST_FSCAL;
            end
          end else begin
            settle_cnt <= settle_cnt - 16'h0001;
          end
        end
        ST_CONV: begin
          if (ADC_DONE_I) begin
            if (ofs_mode) begin
              offset <= ofs_clip;
              if (ofs_hi || ofs_lo)
                range_err <= 1'h1;
              ofs_mode <= 1'h0;
              if (sys) begin
                chan <= `DCC_CH_FS;
                settle_cnt <= SETTLE_CYC;
                state <= ST_SETTLE;
              end else begin
                state <= ST_IDLE;
              end
            end else begin
              state <= ST_AVG;
            end
          end
        end
        // One report per group, otherwise start the next conversion
        ST_AVG: begin
          if (avg_ack) begin
            if (avg_done) begin
              if (word16)
                result <= {8'h00, avg_d[`DCC_F_HI16]};
              else
                result <= avg_d;
              res_rdy <= 1'h1;
              state <= ST_IDLE;
            end else begin
              ADC_START_O <= 1'h1;
              state <= ST_CONV;
            end
          end
        end
        ST_FSCAL: begin
          if (ADC_DONE_I) begin
            if (sys) begin
              chan <= chan_save;
              sys <= 1'h0;
            end
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Converter settings only move while no conversion is running
  always @(posedge CLK_I) begin
    if (!RESETN_I) begin
      ADC_GAIN_O <= `DCC_G1;
      ADC_WORD16_O <= 1'h0;
      ADC_RATE_O <= `DCC_RATE_RST;
      ADC_BIPOLAR_O <= 1'h1;
      ADC_FILTER_O <= `DCC_FLT_400;
      ADC_CHAN_O <= `DCC_CH_RST;
      ADC_STANDBY_O <= 1'h0;
    end else if (!conv_act) begin
      ADC_GAIN_O <= gain;
      ADC_WORD16_O <= word16;
      ADC_RATE_O <= rate;
      ADC_BIPOLAR_O <= bipolar;
      ADC_FILTER_O <= filter;
      ADC_CHAN_O <= chan;
      ADC_STANDBY_O <= stby;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read data captured in the setup phase, presented in access
  always @(posedge CLK_I) begin
    if (!RESETN_I) begin
      PRDATA_O <= 32'h00000000;
    end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      case (PADDR_I)
        `DCC_A_STAT: PRDATA_O <= {24'h000000, a_wait, u_wait, res_rdy,
          range_err, skipped, refused, stby, busy};
        `DCC_A_CFG: PRDATA_O <= {7'h00, rate, avg_exp, chan, filter,
          bipolar, word16, gain};
        `DCC_A_IO: PRDATA_O <= {8'h00, DOUT_O, 4'h0,
          isolated_code_value, din_last};
        `DCC_A_RES: PRDATA_O <= {8'h00, result};
        default: PRDATA_O <= 32'h00000000;
      endcase
    end
  end
endmodule // dcc_ctrl

/* verif/dcc_ctrl_monitor.sv */
// dcc_ctrl_monitor.sv: port-level assertions for the command controller
// Assumes a bind onto dcc_ctrl from the bench top file.
`timescale 1ns/1ps
`include "dcc_defs.vh"
module dcc_ctrl_monitor (
  // Clock, reset and APB request
  input wire CLK_I,
  input wire RESETN_I,
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [7:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  // Watched outputs
  input wire [7:0] DOUT_O,
  input wire [3:0] ISO_O,
  input wire [3:0] ISO_OE_O,
  input wire [2:0] ADC_GAIN_O,
  input wire ADC_WORD16_O,
  input wire [10:0] ADC_RATE_O,
  input wire ADC_BIPOLAR_O,
  input wire [1:0] ADC_FILTER_O,
  input wire [2:0] ADC_CHAN_O,
  input wire ADC_STANDBY_O,
  input wire ADC_START_O,
  input wire ADC_FSCAL_O,
  input wire ADC_DONE_I
);
  ////////////////////////////////////////
  // Decoded request and setting bundle
  wire wr_cmd = PSEL_I && PENABLE_I && PWRITE_I && (PADDR_I == `DCC_A_CMD);
  wire req = ADC_START_O || ADC_FSCAL_O;
  wire [21:0] cfg = {ADC_GAIN_O, ADC_WORD16_O, ADC_RATE_O, ADC_BIPOLAR_O, ADC_FILTER_O, ADC_CHAN_O, ADC_STANDBY_O};
  reg conv_open;
  // Open after a request until the converter answers
  always @(posedge CLK_I) begin
    if (!RESETN_I) conv_open <= 1'b0;
    else if (req) conv_open <= 1'b1;
    else if (ADC_DONE_I) conv_open <= 1'b0;
  end
  ////////////////////////////////////////
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  // Idle standby command, then its effect two edges on (one-cycle copy lag)
  sequence s_stby_cmd;
    wr_cmd && PWDATA_I[7:0] == `DCC_C_STBY && !conv_open;
  endsequence
  sequence s_stby_flip;
    ##2 ADC_STANDBY_O != $past(ADC_STANDBY_O, 2);
  endsequence
  a_iso_pull_only:
    assert property (ISO_O == 4'h0) else $error("isolated pin driven high");
  a_rate_in_range:
    assert property (ADC_RATE_O >= 11'd10 && ADC_RATE_O <= 11'd1027) else $error("rate out of range");
  a_filter_cycles:
    assert property ($changed(ADC_FILTER_O) |-> ADC_FILTER_O == (($past(ADC_FILTER_O) == 2'h2) ? 2'h0
      : $past(ADC_FILTER_O) + 2'h1)) else $error("filter step out of order");
  a_stby_no_start:
    assert property (ADC_STANDBY_O |-> !req) else $error("request in standby");
  a_one_request:
    assert property (conv_open |-> !req) else $error("request while converting");
  a_cfg_frozen:
    assert property (conv_open |=> $stable(cfg)) else $error("setting moved during conversion");
  a_pins_by_cmd:
    assert property (($changed(DOUT_O) || $changed(ISO_OE_O)) |-> $past(wr_cmd)) else $error("pins moved unasked");
  a_stby_toggle:
    assert property (s_stby_cmd |-> s_stby_flip) else $error("standby did not toggle");
endmodule // dcc_ctrl_monitor

/* verif/dcc_adc_model.sv */
// dcc_adc_model.sv: behavioural converter answering the controller
// Assumes single-cycle request pulses on the controller clock.
`timescale 1ns/1ps
module dcc_adc_model (
  // Clock and reset
  input wire clk_i,
  input wire rstn_i,
  // Requests
  input wire start_i,
  input wire fscal_i,
  input wire standby_i,
  // Sample source and answer delay
  input wire [23:0] raw_i,
  input wire [7:0] lat_i,
  // Answer
  output reg done_o,
  output reg [23:0] data_o
);
  reg [7:0] cnt;
  reg busy;
  // One answer per request made outside standby; data toggles between answers so none is stale
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    data_o <= ~data_o;
    if (!rstn_i) begin
      busy <= 1'b0;
      cnt <= 8'h00;
      data_o <= 24'h000000;
    end else if ((start_i || fscal_i) && !standby_i) begin
      busy <= 1'b1;
      cnt <= lat_i;
    end else if (busy && cnt == 8'h00) begin
      busy <= 1'b0;
      done_o <= 1'b1;
      data_o <= raw_i;
    end else if (busy) begin
      cnt <= cnt - 8'h01;
    end
  end
endmodule // dcc_adc_model

/* verif/dcc_ctrl_tb.sv */
// dcc_ctrl_tb.sv: self-checking bench for the command controller
// Assumes the design, converter model and monitor are compiled.
`timescale 1ns/1ps
`include "dcc_defs.vh"
module dcc_ctrl_tb;
  reg CLK_I, RESETN_I, PSEL_I, PENABLE_I, PWRITE_I;
  reg [7:0] PADDR_I, DIN_I, lat;
  reg [31:0] PWDATA_I, rd;
  reg [23:0] raw;
  reg serr;
  reg [2:0] st_ch, fs_ch;
  wire [31:0] PRDATA_O;
  wire PREADY_O, PSLVERR_O, ADC_WORD16_O, ADC_BIPOLAR_O, ADC_STANDBY_O, ADC_START_O, ADC_FSCAL_O, ADC_DONE_I;
  wire [7:0] DOUT_O;
  wire [3:0] ISO_O, ISO_OE_O;
  wire [2:0] ADC_GAIN_O, ADC_CHAN_O;
  wire [10:0] ADC_RATE_O;
  wire [1:0] ADC_FILTER_O;
  wire [23:0] ADC_DATA_I;
  int err_count, compares, n_st, n_fs, b, i;
  // Short settle count keeps calibration runs brief
  dcc_ctrl #(.SETTLE_CYC(16'h0004)) u_dut (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .DIN_I(DIN_I), .DOUT_O(DOUT_O), .ISO_O(ISO_O), .ISO_OE_O(ISO_OE_O),
    .ADC_GAIN_O(ADC_GAIN_O), .ADC_WORD16_O(ADC_WORD16_O), .ADC_RATE_O(ADC_RATE_O), .ADC_BIPOLAR_O(ADC_BIPOLAR_O),
    .ADC_FILTER_O(ADC_FILTER_O), .ADC_CHAN_O(ADC_CHAN_O), .ADC_STANDBY_O(ADC_STANDBY_O),
    .ADC_START_O(ADC_START_O), .ADC_FSCAL_O(ADC_FSCAL_O), .ADC_DONE_I(ADC_DONE_I), .ADC_DATA_I(ADC_DATA_I));
  dcc_adc_model u_adc (.clk_i(CLK_I), .rstn_i(RESETN_I), .start_i(ADC_START_O), .fscal_i(ADC_FSCAL_O),
    .standby_i(ADC_STANDBY_O), .raw_i(raw), .lat_i(lat), .done_o(ADC_DONE_I), .data_o(ADC_DATA_I));
  ////////////////////////////////////////
  // Clock and request log
  initial begin
    CLK_I = 1'b0;
    forever #5 CLK_I = ~CLK_I;
  end
  always @(posedge CLK_I) begin
    if (ADC_START_O === 1'b1) begin
      n_st <= n_st + 1;
      st_ch <= ADC_CHAN_O;
    end
    if (ADC_FSCAL_O === 1'b1) begin
      n_fs <= n_fs + 1;
      fs_ch <= ADC_CHAN_O;
    end
  end
  ////////////////////////////////////////
  task finish_test;
    begin
      $display("mismatches %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  task ck(input [31:0] g, input [31:0] e);
    begin
      compares++;
      if (g !== e) begin
        err_count++;
        $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  // One APB transfer, held until pready, then one idle cycle
  task apb(input [7:0] a, input w, input [31:0] d);
    int n;
    begin
      PSEL_I <= 1'b1;
      PADDR_I <= a;
      PWRITE_I <= w;
      PWDATA_I <= d;
      @(posedge CLK_I);
      PENABLE_I <= 1'b1;
      n = 0;
      do begin
        @(posedge CLK_I);
        n++;
      end while (PREADY_O !== 1'b1 && n < 100);
      if (n >= 100) begin
        err_count++;
        finish_test;
      end
      rd = PRDATA_O;
      serr = PSLVERR_O;
      PSEL_I <= 1'b0;
      PENABLE_I <= 1'b0;
      @(posedge CLK_I);
    end
  endtask
  // Extra edge lets the settings copy land
  task cmd(input [7:0] c, input [15:0] a);
    begin
      apb(`DCC_A_CMD, 1'b1, {8'h00, a, c});
      @(posedge CLK_I);
    end
  endtask
  task wait_idle;
    int n;
    begin
      n = 0;
      do begin
        apb(`DCC_A_STAT, 1'b0, 32'h0);
        n++;
      end while (rd[`DCC_S_BUSY] !== 1'b0 && n < 300);
      if (n >= 300) begin
        err_count++;
        finish_test;
      end
    end
  endtask
  ////////////////////////////////////////
  task t_reset;
    begin
      apb(`DCC_A_CFG, 1'b0, 32'h0);
      ck(rd, 32'h00028010);
      ck({ADC_RATE_O, ADC_BIPOLAR_O, ISO_OE_O}, {11'd10, 1'b1, 4'h0});
      apb(8'h40, 1'b0, 32'h0);
      ck({serr, rd[30:0]}, {1'b1, 31'h0});
    end
  endtask
  task t_digital;
    begin
      DIN_I <= 8'hA5;
      cmd(`DCC_C_DIN, 16'h0);
      DIN_I <= 8'h5A;
      cmd(`DCC_C_EXT, 16'h0009);
      ck({ISO_OE_O, ISO_O}, 8'h90);
      cmd(`DCC_C_DOUT, 16'h0);
      apb(`DCC_A_STAT, 1'b0, 32'h0);
      ck(rd[`DCC_S_UWAIT], 1'b1);
      cmd(8'h3C, 16'h0);
      cmd(`DCC_C_WORD, 16'h0);
      cmd(`DCC_C_WORD, 16'h0);
      apb(`DCC_A_IO, 1'b0, 32'h0);
      ck(rd, 32'h003C09A5);
    end
  endtask
  task t_setup;
    begin
      for (i = 0; i < 8; i++) begin
        cmd(`DCC_C_GAIN, 16'h0001 << i);
        ck(ADC_GAIN_O, i);
      end
      cmd(`DCC_C_GAIN, 16'h0003);
      apb(`DCC_A_STAT, 1'b0, 32'h0);
      ck({rd[`DCC_S_REF], ADC_GAIN_O}, 4'hF);
      cmd(`DCC_C_GAIN, 16'h0001);
      cmd(`DCC_C_RATE, 16'd1027);
      ck(ADC_RATE_O, 11'd1027);
      cmd(`DCC_C_RATE, 16'd10);
      ck(ADC_RATE_O, 11'd10);
      cmd(`DCC_C_RATE, 16'd9);
      cmd(`DCC_C_RATE, 16'd1028);
      ck(ADC_RATE_O, 11'd10);
      cmd(`DCC_C_RATE, 16'd1027);
      for (i = 0; i < 6; i++) begin
        cmd(`DCC_C_FILT, 16'h0);
        ck(ADC_FILTER_O, (i + 1) % 3);
      end
      cmd(`DCC_C_WORD, 16'h0);
      cmd(`DCC_C_POL, 16'h0);
      ck({ADC_WORD16_O, ADC_BIPOLAR_O}, 2'b10);
      cmd(`DCC_C_WORD, 16'h0);
      cmd(`DCC_C_POL, 16'h0);
      ck({ADC_WORD16_O, ADC_BIPOLAR_O}, 2'b01);
      apb(`DCC_A_STAT, 1'b1, 32'h0000001C);
    end
  endtask
  // Offset, single and averaged conversions, busy refusal, clamp
  task t_conv;
    begin
      raw <= 24'h800100;
      cmd(`DCC_C_OFS, 16'h0);
      wait_idle;
      cmd(`DCC_C_CONV, 16'h0);
      wait_idle;
      ck(rd[`DCC_S_RES], 1'b1);
      apb(`DCC_A_RES, 1'b0, 32'h0);
      ck(rd, 32'h00800000);
      cmd(`DCC_C_AVG, 16'h0);
      cmd(`DCC_C_PLUS, 16'h0);
      apb(`DCC_A_CFG, 1'b0, 32'h0);
      ck(rd[13:10], 4'h0);
      cmd(`DCC_C_PLUS, 16'h0);
      cmd(`DCC_C_ENTER, 16'h0);
      raw <= 24'h900100;
      lat <= 8'd20;
      b = n_st;
      cmd(`DCC_C_CONV, 16'h0);
      cmd(`DCC_C_FILT, 16'h0);
      ck(ADC_FILTER_O, 2'h0);
      wait_idle;
      ck({rd[`DCC_S_REF], rd[`DCC_S_RES]}, 2'b11);
      ck(n_st - b, 4);
      apb(`DCC_A_RES, 1'b0, 32'h0);
      ck(rd, 32'h00900000);
      cmd(`DCC_C_WORD, 16'h0);
      cmd(`DCC_C_CONV, 16'h0);
      wait_idle;
      apb(`DCC_A_RES, 1'b0, 32'h0);
      ck(rd, 32'h00009000);
      cmd(`DCC_C_WORD, 16'h0);
      raw <= 24'h900000;
      lat <= 8'd3;
      cmd(`DCC_C_OFS, 16'h0);
      wait_idle;
      ck(rd[`DCC_S_RANGE], 1'b1);
      cmd(`DCC_C_CONV, 16'h0);
      wait_idle;
      apb(`DCC_A_RES, 1'b0, 32'h0);
      ck(rd, 32'h00833334);
    end
  endtask
  task t_stby;
    begin
      apb(`DCC_A_STAT, 1'b1, 32'h0000001C);
      cmd(`DCC_C_STBY, 16'h0);
      ck(ADC_STANDBY_O, 1'b1);
      b = n_st;
      cmd(`DCC_C_CONV, 16'h0);
      apb(`DCC_A_STAT, 1'b0, 32'h0);
      ck({rd[`DCC_S_REF], rd[`DCC_S_STBY]}, 2'b11);
      apb(`DCC_A_CFG, 1'b0, 32'h0);
      ck(rd, 32'h0100C810);
      ck(n_st - b, 0);
      cmd(`DCC_C_STBY, 16'h0);
      ck(ADC_STANDBY_O, 1'b0);
    end
  endtask
  task t_cal;
    begin
      cmd(`DCC_C_CHAN, 16'h0003);
      ck(ADC_CHAN_O, 3'h3);
      cmd(`DCC_C_SYS, 16'h0);
      wait_idle;
      ck({st_ch, fs_ch, ADC_CHAN_O}, {3'h7, 3'h6, 3'h3});
      b = n_fs;
      cmd(`DCC_C_FS, 16'h0);
      wait_idle;
      ck({n_fs - b, fs_ch}, {32'd1, 3'h3});
      cmd(`DCC_C_GAIN, 16'h0002);
      b = n_fs;
      cmd(`DCC_C_SYS, 16'h0);
      apb(`DCC_A_STAT, 1'b0, 32'h0);
      ck({rd[`DCC_S_SKIP], 16'(n_fs - b)}, {1'b1, 16'h0});
    end
  endtask
  ////////////////////////////////////////
  initial begin
    RESETN_I = 1'b0;
    PSEL_I = 1'b0;
    PENABLE_I = 1'b0;
    PWRITE_I = 1'b0;
    PADDR_I = 8'h00;
    PWDATA_I = 32'h0;
    DIN_I = 8'h00;
    raw = 24'h000000;
    lat = 8'd3;
    repeat (20) @(posedge CLK_I);
    RESETN_I <= 1'b1;
    @(posedge CLK_I);
    t_reset;
    t_digital;
    t_setup;
    t_conv;
    t_stby;
    t_cal;
    finish_test;
  end
endmodule // dcc_ctrl_tb
bind dcc_ctrl dcc_ctrl_monitor u_mon (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .DOUT_O(DOUT_O), .ISO_O(ISO_O), .ISO_OE_O(ISO_OE_O),
  .ADC_GAIN_O(ADC_GAIN_O), .ADC_WORD16_O(ADC_WORD16_O), .ADC_RATE_O(ADC_RATE_O), .ADC_BIPOLAR_O(ADC_BIPOLAR_O),
  .ADC_FILTER_O(ADC_FILTER_O), .ADC_CHAN_O(ADC_CHAN_O), .ADC_STANDBY_O(ADC_STANDBY_O),
  .ADC_START_O(ADC_START_O), .ADC_FSCAL_O(ADC_FSCAL_O), .ADC_DONE_I(ADC_DONE_I));
